// file: core_state_pkg.sv
// core_state_pkg: constants for the core architectural state block
// assumes: included before any module of the block; no other dependencies
package core_state_pkg;
  // ==========================================================
  // register file shape
  localparam int unsigned XLEN = 32;
  localparam int unsigned NUM_REGS = 16;
  localparam logic [3:0] IDX_LOW_LAST = 4'h7;
  localparam logic [3:0] IDX_HIGH_LAST = 4'hc;
  localparam logic [3:0] IDX_STACK = 4'hd;
  localparam logic [3:0] IDX_LINK = 4'he;
  localparam logic [3:0] IDX_PC = 4'hf;
  // ==========================================================
  // reset vectors and address map
  localparam logic [31:0] VEC_STACK_ADDR = 32'h0000_0000;
  localparam logic [31:0] VEC_PC_ADDR = 32'h0000_0004;
  localparam logic [2:0] REGION_CODE = 3'h0;
  localparam logic [2:0] REGION_SRAM = 3'h1;
  localparam logic [2:0] REGION_PERIPH = 3'h2;
  localparam logic [11:0] PRIVATE_TOP12 = 12'he00;
  // ==========================================================
  // status bit positions
  localparam int unsigned EXEC_STATE_BIT = 24;
  localparam int unsigned CTRL_SPSEL_BIT = 1;
  localparam int unsigned MASK_BIT = 0;
  localparam int unsigned EXC_NUM_W = 6;
  localparam logic [5:0] EXC_THREAD = 6'h00;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD_FAULT = 6'h03;
  // ==========================================================
  // AXI4-Lite register offsets
  localparam logic [7:0] OFF_GPR_BASE = 8'h00;
  localparam logic [7:0] OFF_MAIN_SP = 8'h40;
  localparam logic [7:0] OFF_PROC_SP = 8'h44;
  localparam logic [7:0] OFF_PSR = 8'h48;
  localparam logic [7:0] OFF_MASK = 8'h4c;
  localparam logic [7:0] OFF_CONTROL = 8'h50;
  localparam logic [7:0] OFF_STATUS = 8'h54;
  localparam logic [7:0] OFF_EXC_NUM = 8'h58;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // reset sequencer
  typedef enum logic [1:0] {
    SEQ_FETCH_SP = 2'b00,
    SEQ_FETCH_PC = 2'b01,
    SEQ_RUN = 2'b11
  } seq_state_t;
endpackage : core_state_pkg

// file: addr_region_decode.sv
// addr_region_decode: maps a 32-bit address to a region with execute permission
// assumes: purely combinational, used once for fetches and once for data
`timescale 1ns/1ps
`default_nettype none
module addr_region_decode
  import core_state_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic is_fetch,
  output logic [2:0] region,
  output logic is_private,
  output logic is_mapped,
  output logic allowed
);
  // ==========================================================
  // region decode
  always_comb begin
    region = addr[31:29];
    is_private = (addr[31:20] == PRIVATE_TOP12);
    is_mapped = (region == REGION_CODE) || (region == REGION_SRAM) ||
                (region == REGION_PERIPH) || is_private;
    if (is_fetch) begin
      allowed = (region == REGION_CODE) || (region == REGION_SRAM);
    end else begin
      allowed = is_mapped;
    end
  end
endmodule : addr_region_decode
`default_nettype wire

// file: core_state.sv
// core_state: architectural register state, reset vector fetch and address map
// assumes: one 20 MHz clock, synchronous active-low reset, memory answers
// vector reads on a valid/ready port, the execute stage drives the write ports
// Operation
// - sixteen 32-bit registers on a 32-bit datapath and memory port
// - registers 0-7 usable by all, 8-12 by a subset only
// - register 13 banked; control bit 1 picks process pointer in thread mode
// - after reset load main stack pointer from word at address zero
// - after reset load program counter from word at address four
// - vector bit 0 goes to execution-state bit; must be one
// - decode code, sram and peripheral regions from fixed bases
// - fetch allowed from code and sram only, data from any mapped region
// - 0xE0000000-0xE00FFFFF decodes to core-private space
// - register 14 holds return info; undefined after reset
// - register 15 holds program address; write redirects fetch
// - status flags keep earlier results; undefined reset value
// - exception number read-only, resets to zero
// - mask register resets to zero, blocks configurable exceptions
// - 32x32 multiply in one cycle, low 32 bits of the product only
// - pipeline of exactly three stages
// - mask bit 0 set disables all but hard fault, nmi, reset
// - handler mode uses main pointer; control writes ignored there
// - executing with execution-state bit clear raises hard fault
`timescale 1ns/1ps
`default_nettype none
module core_state
  import core_state_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // vector fetch port
  output logic vec_req,
  output logic [31:0] vec_addr,
  input wire logic vec_ack,
  input wire logic [31:0] vec_data,
  // execute stage access
  input wire logic [3:0] rd_sel_a,
  input wire logic [3:0] rd_sel_b,
  input wire logic rd_full_set,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b,
  output logic rd_sel_illegal,
  input wire logic wr_en,
  input wire logic [3:0] wr_sel,
  input wire logic [31:0] wr_data,
  input wire logic flags_we,
  input wire logic [3:0] flags_in,
  input wire logic mask_we,
  input wire logic mask_in,
  input wire logic control_we,
  input wire logic control_in,
  input wire logic exc_enter,
  input wire logic exc_return,
  input wire logic [5:0] exc_num_in,
  input wire logic [31:0] exc_link,
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  output logic [31:0] mul_result,
  // pipeline and fetch
  input wire logic issue,
  input wire logic [31:0] data_addr,
  output logic running,
  output logic [31:0] fetch_addr,
  output logic fetch_fault,
  output logic data_fault,
  output logic data_private,
  output logic hard_fault_a,
  output logic [2:0] stage_valid,
  input wire logic [5:0] exc_req_num,
  input wire logic exc_req,
  output logic exc_allowed,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  // ==========================================================
  // state
  // sixteen 32-bit entries, 13 of them general
  logic [31:0] gpr_r [0:12];
  logic [31:0] main_stack_pointer_r;
  logic [31:0] process_stack_pointer_r;
  logic [31:0] link_register_r;
  logic [31:0] program_counter_r;
  logic [3:0] flags_r;
  logic exec_state_r;
  logic [5:0] exc_num_r;
  logic mask_r;
  logic spsel_r;
  seq_state_t seq_r;
  logic [2:0] pipe_r;
  logic [31:0] reg_view [0:15];
  logic handler_mode;
  logic use_process_sp;
  logic [31:0] stack_view;
  logic [31:0] psr_view;

  // bus-side decoded writes
  logic bus_wr;
  logic [7:0] bus_wr_addr;
  logic [31:0] bus_wr_data;

  assign handler_mode = (exc_num_r != EXC_THREAD);
  assign use_process_sp = spsel_r && !handler_mode;
  assign stack_view = use_process_sp ? process_stack_pointer_r : main_stack_pointer_r;
  assign running = (seq_r == SEQ_RUN);
  assign psr_view = {flags_r, 3'h0, exec_state_r, 18'h0_0000, exc_num_r};

  always_comb begin
    for (int i = 0; i < 13; i++) begin
      reg_view[i] = gpr_r[i];
    end
    reg_view[13] = stack_view;
    reg_view[14] = link_register_r;
    reg_view[15] = program_counter_r;
  end

  // high registers only for full-set instructions
  assign rd_sel_illegal = !rd_full_set &&
      ((rd_sel_a > IDX_LOW_LAST && rd_sel_a <= IDX_HIGH_LAST) ||
       (rd_sel_b > IDX_LOW_LAST && rd_sel_b <= IDX_HIGH_LAST));
  assign rd_data_a = reg_view[rd_sel_a];
  assign rd_data_b = reg_view[rd_sel_b];

  assign mul_result = mul_a * mul_b;

  // ==========================================================
  // reset sequencer
  // word at zero first, then word at four
  assign vec_req = (seq_r != SEQ_RUN);
  assign vec_addr = (seq_r == SEQ_FETCH_SP) ? VEC_STACK_ADDR : VEC_PC_ADDR;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_r <= SEQ_FETCH_SP;
    end else begin
      case (seq_r)
        SEQ_FETCH_SP: begin
          if (vec_ack) begin
            seq_r <= SEQ_FETCH_PC;
          end
        end
        SEQ_FETCH_PC: begin
          if (vec_ack) begin
            seq_r <= SEQ_RUN;
          end
        end
        SEQ_RUN: seq_r <= SEQ_RUN;
        default: seq_r <= SEQ_FETCH_SP;
      endcase
    end
  end

  // ==========================================================
  // general registers and link
  // no reset on link; alike for flags
  always_ff @(posedge clk) begin
    if (running && wr_en && wr_sel <= IDX_HIGH_LAST) begin
      gpr_r[wr_sel] <= wr_data;
    end else if (bus_wr && bus_wr_addr[7:6] == OFF_GPR_BASE[7:6] &&
                 bus_wr_addr[5:2] <= IDX_HIGH_LAST) begin
      gpr_r[bus_wr_addr[5:2]] <= bus_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    // return info on call or exception entry
    if (exc_enter) begin
      link_register_r <= exc_link;
    end else if (running && wr_en && wr_sel == IDX_LINK) begin
      link_register_r <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (flags_we) begin
      flags_r <= flags_in;
    end else if (bus_wr && bus_wr_addr == OFF_PSR) begin
      flags_r <= bus_wr_data[31:28];
    end
  end

  // ==========================================================
  // stack pointers
  always_ff @(posedge clk) begin
    if (seq_r == SEQ_FETCH_SP && vec_ack) begin
      main_stack_pointer_r <= vec_data;
    end else if (running && wr_en && wr_sel == IDX_STACK && !use_process_sp) begin
      main_stack_pointer_r <= wr_data;
    end else if (bus_wr && bus_wr_addr == OFF_MAIN_SP) begin
      main_stack_pointer_r <= bus_wr_data;
    end
  end

  always_ff @(posedge clk) begin
    // execute writes reach process pointer only when selected; bus writes always
    if (running && wr_en && wr_sel == IDX_STACK && use_process_sp) begin
      process_stack_pointer_r <= wr_data;
    end else if (bus_wr && bus_wr_addr == OFF_PROC_SP) begin
      process_stack_pointer_r <= bus_wr_data;
    end
  end

  // ==========================================================
  // program counter and execution state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      program_counter_r <= VEC_STACK_ADDR;
      exec_state_r <= 1'b0;
    end else if (seq_r == SEQ_FETCH_PC && vec_ack) begin
      program_counter_r <= {vec_data[31:1], 1'b0};
      // vector bit 0 into execution state
      exec_state_r <= vec_data[0];
    end else if (running && wr_en && wr_sel == IDX_PC) begin
      program_counter_r <= {wr_data[31:1], 1'b0};
    end else if (running && issue) begin
      program_counter_r <= program_counter_r + 32'h0000_0002;
    end
  end
  assign fetch_addr = program_counter_r;

  // ==========================================================
  // exception number, mask, control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // resets to zero, software cannot write it
      exc_num_r <= EXC_THREAD;
    end else if (exc_enter) begin
      exc_num_r <= exc_num_in;
    end else if (exc_return) begin
      exc_num_r <= EXC_THREAD;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r <= 1'b0;
    end else if (mask_we) begin
      mask_r <= mask_in;
    end else if (bus_wr && bus_wr_addr == OFF_MASK) begin
      mask_r <= bus_wr_data[MASK_BIT];
    end
  end

  // mask spares hard fault and nmi
  assign exc_allowed = exc_req && (!mask_r || exc_req_num == EXC_NMI ||
                                   exc_req_num == EXC_HARD_FAULT);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spsel_r <= 1'b0;
    end else if (exc_enter) begin
      spsel_r <= 1'b0;
    end else if (!handler_mode) begin
      // explicit writes ignored in handler mode
      if (control_we) begin
        spsel_r <= control_in;
      end else if (bus_wr && bus_wr_addr == OFF_CONTROL) begin
        spsel_r <= bus_wr_data[CTRL_SPSEL_BIT];
      end
    end
  end

  // ==========================================================
  // three-stage pipeline occupancy and faults
  // execution-state bit clear faults on issue
  assign hard_fault_a = running && issue && !exec_state_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pipe_r <= 3'h0;
    end else if (hard_fault_a || (running && wr_en && wr_sel == IDX_PC)) begin
      // a redirect flushes what was fetched behind it
      pipe_r <= 3'h0;
    end else begin
      pipe_r <= {pipe_r[1:0], running && issue};
    end
  end
  assign stage_valid = pipe_r;

  logic fetch_ok;
  logic data_ok;
  addr_region_decode u_fetch_dec (
    .addr(program_counter_r),
    .is_fetch(1'b1),
    .region(),
    .is_private(),
    .is_mapped(),
    .allowed(fetch_ok)
  );
  addr_region_decode u_data_dec (
    .addr(data_addr),
    .is_fetch(1'b0),
    .region(),
    .is_private(data_private),
    .is_mapped(),
    .allowed(data_ok)
  );
  assign fetch_fault = running && !fetch_ok;
  assign data_fault = !data_ok;

  // ==========================================================
  // AXI4-Lite slave
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] wr_merge;
  logic wr_known;

  assign s_awready = !aw_held_r && !s_bvalid;
  assign s_wready = !w_held_r && !s_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
      end
      if (bus_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  assign bus_wr = aw_held_r && w_held_r && !s_bvalid;
  assign bus_wr_addr = awaddr_r;
  always_comb begin
    wr_merge = reg_read(awaddr_r);
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) begin
        wr_merge[b*8 +: 8] = wdata_r[b*8 +: 8];
      end
    end
  end
  assign bus_wr_data = wr_merge;
  assign wr_known = (awaddr_r[7:6] == OFF_GPR_BASE[7:6] && awaddr_r[5:2] <= IDX_HIGH_LAST) ||
      awaddr_r == OFF_MAIN_SP || awaddr_r == OFF_PROC_SP || awaddr_r == OFF_PSR ||
      awaddr_r == OFF_MASK || awaddr_r == OFF_CONTROL;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a[7:6] == OFF_GPR_BASE[7:6]) begin
      v = reg_view[a[5:2]];
    end else begin
      case (a)
        OFF_MAIN_SP: v = main_stack_pointer_r;
        OFF_PROC_SP: v = process_stack_pointer_r;
        OFF_PSR: v = psr_view;
        OFF_MASK: v = {31'h0000_0000, mask_r};
        OFF_CONTROL: v = {30'h0000_0000, spsel_r, 1'b0};
        OFF_STATUS: v = {29'h0000_0000, handler_mode, use_process_sp, running};
        OFF_EXC_NUM: v = {26'h000_0000, exc_num_r};
        default: v = 32'h0000_0000;
      endcase
    end
    return v;
  endfunction : reg_read

  function automatic logic rd_known(input logic [7:0] a);
    return (a[7:6] == OFF_GPR_BASE[7:6]) || a == OFF_MAIN_SP || a == OFF_PROC_SP ||
        a == OFF_PSR || a == OFF_MASK || a == OFF_CONTROL || a == OFF_STATUS ||
        a == OFF_EXC_NUM;
  endfunction : rd_known

  assign s_arready = !s_rvalid;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= reg_read(s_araddr);
      s_rresp <= rd_known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : core_state
`default_nettype wire

// file: core_state_sva.sv
// core_state_sva: concurrent checks on the core state block ports
// assumes: bound into core_state, single clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module core_state_sva
  import core_state_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vec_req,
  input wire logic [31:0] vec_addr,
  input wire logic vec_ack,
  input wire logic running,
  input wire logic [3:0] rd_sel_a,
  input wire logic [3:0] rd_sel_b,
  input wire logic rd_full_set,
  input wire logic rd_sel_illegal,
  input wire logic [31:0] mul_a,
  input wire logic [31:0] mul_b,
  input wire logic [31:0] mul_result,
  input wire logic exc_req,
  input wire logic [5:0] exc_req_num,
  input wire logic exc_allowed,
  input wire logic [31:0] data_addr,
  input wire logic data_private,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch_fault
);
  logic hi_a;
  logic hi_b;
  assign hi_a = (rd_sel_a > IDX_LOW_LAST) && (rd_sel_a <= IDX_HIGH_LAST);
  assign hi_b = (rd_sel_b > IDX_LOW_LAST) && (rd_sel_b <= IDX_HIGH_LAST);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // reset vector sequence
  stack_vec_first_a: assert property ($rose(rst_n) |-> vec_req && vec_addr == VEC_STACK_ADDR)
    else $error("first vector read is not word zero");
  pc_vec_next_a: assert property (vec_req && vec_ack && vec_addr == VEC_STACK_ADDR
    |=> vec_req && vec_addr == VEC_PC_ADDR)
    else $error("second vector read is not word four");
  run_after_vec_a: assert property (vec_req && vec_ack && vec_addr == VEC_PC_ADDR
    |=> running && !vec_req)
    else $error("core did not start after vectors");
  // ==========================================================
  // operand access, multiply, masking, address map
  high_sel_gate_a: assert property (rd_sel_illegal == (!rd_full_set && (hi_a || hi_b)))
    else $error("high register restriction wrong");
  mul_single_a: assert property (mul_result == 32'(mul_a * mul_b))
    else $error("multiply result wrong");
  nmask_pass_a: assert property (exc_req && (exc_req_num == EXC_NMI
    || exc_req_num == EXC_HARD_FAULT) |-> exc_allowed)
    else $error("unmaskable exception blocked");
  private_map_a: assert property (data_private == (data_addr[31:20] == PRIVATE_TOP12))
    else $error("private space decode wrong");
  fetch_perm_a: assert property (running |-> fetch_fault == (fetch_addr[31:30] != 2'b00))
    else $error("execute permission wrong");
endmodule : core_state_sva
`default_nettype wire

// file: vec_mem_model.sv
// vec_mem_model: boot memory that answers the two reset vector reads
// assumes: one outstanding vector read, core clock only
`timescale 1ns/1ps
`default_nettype none
module vec_mem_model
  import core_state_pkg::*;
#(
  parameter logic [31:0] SP_WORD = 32'h2000_1000
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vec_req,
  input wire logic [31:0] vec_addr,
  input wire logic [31:0] pc_word,
  input wire logic [1:0] lat,
  output logic vec_ack,
  output logic [31:0] vec_data
);
  logic [1:0] wait_r;
  // ==========================================================
  // answer after lat idle cycles; data toggles when not valid
  // word by address, bit 0 comes from pc_word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vec_ack <= 1'b0;
      wait_r <= 2'h0;
    end else if (vec_ack || !vec_req) begin
      vec_ack <= 1'b0;
      wait_r <= 2'h0;
      vec_data <= ~vec_data;
    end else if (wait_r == lat) begin
      vec_ack <= 1'b1;
      vec_data <= (vec_addr == VEC_STACK_ADDR) ? SP_WORD : pc_word;
    end else begin
      wait_r <= wait_r + 2'h1;
      vec_data <= ~vec_data;
    end
  end
endmodule : vec_mem_model
`default_nettype wire

// file: core_state_tb_top.sv
// core_state_tb_top: directed bench for the core state block
// assumes: vec_mem_model on the vector port, bus driven as AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module core_state_tb_top;
  import core_state_pkg::*;
  localparam logic [31:0] SP_W = 32'h2000_1000;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [7:0] RST_OFF [4] = '{OFF_MASK, OFF_CONTROL, OFF_EXC_NUM, OFF_STATUS};
  localparam logic [31:0] RST_EXP [4] = '{32'h0, 32'h0, 32'h0, 32'h1};
  localparam logic [5:0] NUMS [3] = '{6'h05, EXC_NMI, EXC_HARD_FAULT};
  localparam logic [31:0] DADDR [5] = '{32'h0, 32'h2000_0000, 32'h4000_0000,
    32'h6000_0000, 32'he000_0000};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vec_req, vec_ack, rd_sel_illegal, running, fetch_fault, data_fault;
  logic data_private, hard_fault_a, exc_allowed;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, r;
  logic [2:0] stage_valid;
  logic [31:0] vec_addr, vec_data, rd_data_a, rd_data_b, mul_result, fetch_addr, s_rdata, d;
  logic [31:0] pc_word = 32'h0000_0101;
  logic [1:0] lat = 2'h0;
  logic [3:0] rd_sel_a = 4'h0, rd_sel_b = 4'h0, wr_sel = 4'h0, flags_in = 4'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic rd_full_set = 1'b0, wr_en = 1'b0, flags_we = 1'b0, mask_we = 1'b0, mask_in = 1'b0;
  logic control_we = 1'b0, control_in = 1'b1, exc_enter = 1'b0, exc_return = 1'b0;
  logic issue = 1'b0, exc_req = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic [5:0] exc_num_in = 6'h0, exc_req_num = 6'h0;
  logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
  logic [31:0] wr_data = 32'h0, exc_link = 32'h0, mul_a = 32'h0, mul_b = 32'h0;
  logic [31:0] data_addr = 32'h0, s_wdata = 32'h0;
  int error_cnt = 0, checks = 0, cyc = 0;
  core_state u_core_state (.clk, .rst_n, .vec_req, .vec_addr, .vec_ack, .vec_data,
    .rd_sel_a, .rd_sel_b, .rd_full_set, .rd_data_a, .rd_data_b, .rd_sel_illegal,
    .wr_en, .wr_sel, .wr_data, .flags_we, .flags_in, .mask_we, .mask_in, .control_we,
    .control_in, .exc_enter, .exc_return, .exc_num_in, .exc_link, .mul_a, .mul_b,
    .mul_result, .issue, .data_addr, .running, .fetch_addr, .fetch_fault, .data_fault,
    .data_private, .hard_fault_a, .stage_valid, .exc_req_num, .exc_req, .exc_allowed,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready);
  vec_mem_model #(.SP_WORD(SP_W)) u_vec_mem_model (.clk, .rst_n, .vec_req, .vec_addr,
    .pc_word, .lat, .vec_ack, .vec_data);
  initial forever #25 clk = ~clk;
  // ==========================================================
  // shared tasks
  task automatic tally_and_finish;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask : axi_rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a, d, r);
    chk("bus read", d & m, e);
    chk("bus resp", 32'(r), 32'(RESP_OKAY));
  endtask : rchk
  task automatic ex_wr(input logic [3:0] s, input logic [31:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : ex_wr
  // one-cycle pulse on {issue, flags_we, mask_we, control_we, exc_return, exc_enter}
  task automatic strobe(input logic [5:0] k);
    @(posedge clk);
    {issue, flags_we, mask_we, control_we, exc_return, exc_enter} <= k;
    @(posedge clk);
    {issue, flags_we, mask_we, control_we, exc_return, exc_enter} <= 6'h00;
  endtask : strobe
  task automatic rsel(input logic [3:0] s, input logic [31:0] e);
    @(posedge clk);
    rd_sel_a <= s;
    @(negedge clk);
    chk("operand", rd_data_a, e);
  endtask : rsel
  task automatic boot(input logic [31:0] w, input logic [1:0] l);
    @(posedge clk);
    rst_n <= 1'b0;
    pc_word <= w;
    lat <= l;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    while (running !== 1'b1) @(posedge clk);
  endtask : boot
  // hang guard: the run needs under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    boot(32'h0000_0101, 2'h0);
    rchk(OFF_MAIN_SP, ALL, SP_W);
    chk("start pc", fetch_addr & 32'hffff_fffe, 32'h0000_0100);
    rchk(OFF_PSR, 32'h0100_0000, 32'h0100_0000);
    foreach (RST_OFF[i]) rchk(RST_OFF[i], ALL, RST_EXP[i]);
    axi_rd(8'h80, d, r);
    chk("unmapped rd", 32'(r), 32'(RESP_SLVERR));
    axi_wr(8'h80, 32'h1, r);
    chk("unmapped wr", 32'(r), 32'(RESP_SLVERR));
    axi_wr(OFF_EXC_NUM, 32'h5, r);
    rchk(OFF_EXC_NUM, ALL, 32'h0);
    for (int i = 0; i < 13; i++) begin
      ex_wr(4'(i), 32'h5a5a_0000 | 32'(i));
      rd_full_set <= i[0];
      rd_sel_b <= 4'(i);
      @(negedge clk);
      chk("gpr", rd_data_b, 32'h5a5a_0000 | 32'(i));
    end
    rchk(OFF_GPR_BASE + 8'h1c, ALL, 32'h5a5a_0007);
    axi_wr(OFF_MAIN_SP, 32'h2000_0800, r);
    axi_wr(OFF_PROC_SP, 32'h2000_0400, r);
    rsel(IDX_STACK, 32'h2000_0800);
    axi_wr(OFF_CONTROL, 32'h0000_0002, r);
    rsel(IDX_STACK, 32'h2000_0400);
    rchk(OFF_STATUS, 32'h0000_0007, 32'h0000_0003);
    exc_num_in <= EXC_HARD_FAULT;
    exc_link <= 32'h0000_0201;
    strobe(6'h01);
    rsel(IDX_STACK, 32'h2000_0800);
    rsel(IDX_LINK, 32'h0000_0201);
    rchk(OFF_EXC_NUM, ALL, 32'h0000_0003);
    axi_wr(OFF_CONTROL, 32'h0000_0002, r);
    strobe(6'h04);
    rchk(OFF_CONTROL, 32'h0000_0002, 32'h0);
    strobe(6'h02);
    rchk(OFF_EXC_NUM, ALL, 32'h0);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) axi_wr(OFF_MASK, 32'h1, r);
      foreach (NUMS[j]) begin
        @(posedge clk);
        exc_req <= 1'b1;
        exc_req_num <= NUMS[j];
        @(negedge clk);
        chk("allowed", 32'(exc_allowed), 32'(m == 0 || NUMS[j] != 6'h05));
      end
    end
    rchk(OFF_MASK, ALL, 32'h1);
    strobe(6'h08);
    rchk(OFF_MASK, ALL, 32'h0);
    flags_in <= 4'ha;
    strobe(6'h10);
    rchk(OFF_PSR, 32'hf000_0000, 32'ha000_0000);
    ex_wr(IDX_PC, 32'h2000_0011);
    @(negedge clk);
    chk("redirect", fetch_addr, 32'h2000_0010);
    strobe(6'h20);
    @(negedge clk);
    chk("advance", fetch_addr, 32'h2000_0012);
    chk("stage", 32'(stage_valid), 32'h1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("stage2", 32'(stage_valid), 32'h4);
    ex_wr(IDX_PC, 32'h4000_0000);
    @(negedge clk);
    chk("no execute", 32'(fetch_fault), 32'h1);
    foreach (DADDR[k]) begin
      @(posedge clk);
      data_addr <= DADDR[k];
      @(negedge clk);
      chk("data fault", 32'(data_fault), 32'(k == 3));
      chk("private", 32'(data_private), 32'(k == 4));
    end
    @(posedge clk);
    mul_a <= 32'hffff_ffff;
    mul_b <= 32'hffff_fffd;
    @(negedge clk);
    chk("multiply", mul_result, 32'h0000_0003);
    // slow memory, vector bit 0 clear
    boot(32'h0000_0100, 2'h3);
    rchk(OFF_MAIN_SP, ALL, SP_W);
    rchk(OFF_PSR, 32'h0100_0000, 32'h0);
    @(posedge clk);
    issue <= 1'b1;
    @(negedge clk);
    chk("hard fault", 32'(hard_fault_a), 32'h1);
    tally_and_finish();
  end
endmodule : core_state_tb_top
bind core_state core_state_sva u_core_state_sva (.clk, .rst_n, .vec_req, .vec_addr,
  .vec_ack, .running, .rd_sel_a, .rd_sel_b, .rd_full_set, .rd_sel_illegal, .mul_a,
  .mul_b, .mul_result, .exc_req, .exc_req_num, .exc_allowed, .data_addr, .data_private,
  .fetch_addr, .fetch_fault);
`default_nettype wire
